// ---- token_node_ctrl.sv ----
// token bus node controller with wishbone register slave
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// R1 - only the token holder sends data frames on the shared bus
// R2 - token goes in ascending node order starting at the polling node
// R3 - holder with nothing queued passes the token at once
// R4 - highest member returns the token to the lowest member
// R5 - on silence the next higher node takes over polling
// R6 - after the token cycle the poller polls nodes and broadcasts membership
// R7 - after polling the poller issues the token again
// R8 - poller broadcasts cycle time, poll count, frame limit, max address
// R9 - link runs with the starting node's parameters
// R10 - unit number is tens switch times ten plus ones switch
// R11 - unit number above 15 lights the unit number error lamp
// R12 - unit address is 10 hex plus unit number, host 00, board 01
// R13 - group-2 slave address is 90 plus slave plus ten times master (code adds sixteen times master)
// R14 - message to unit FE reaches this link unit whatever its number
// R15 - node address from two decimal switches, 01 to 62, unique
// R16 - node address outside 01 to 62 lights the link error lamp
// R17 - nodes above max address are not polled and stay silent
// R18 - membership list from broadcast picks the next token target
module token_node_ctrl
  import token_node_pkg::*;
#(
  parameter int SILENCE_CYCLES = SILENCE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic [3:0] unit_tens_switch,
  input wire logic [3:0] unit_ones_switch,
  input wire logic [3:0] node_tens_switch,
  input wire logic [3:0] node_ones_switch,
  output logic unit_number_error_lamp,
  output logic link_comm_error_lamp,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [2:0] tx_kind,
  output logic [5:0] tx_dst,
  output logic [63:0] tx_data,
  input wire logic rx_valid,
  input wire logic [2:0] rx_kind,
  input wire logic [5:0] rx_src,
  input wire logic [5:0] rx_dst,
  input wire logic [63:0] rx_data,
  output logic token_held,
  output logic poller
);
  // ----------------------------------------------------------------
  // switch synchronisers
  // ----------------------------------------------------------------
  logic [15:0] sw_meta_r, sw_sync_r;
  always_ff @(posedge clk) begin
    sw_meta_r <= {unit_tens_switch, unit_ones_switch, node_tens_switch, node_ones_switch};
    sw_sync_r <= sw_meta_r;
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t state_r, state_nxt;
  logic [6:0] unit_r, unit_nxt, node_r, node_nxt;
  logic unit_err_r, unit_err_nxt, node_err_r, node_err_nxt;
  logic ctrl_en_r, ctrl_en_nxt, ack_r, ack_nxt, irq_r, irq_nxt;
  logic [31:0] rdat_r, rdat_nxt, params_r, params_nxt, active_r, active_nxt;
  logic [31:0] txw_r, txw_nxt, rxw_r, rxw_nxt;
  logic [5:0] g2_r, g2_nxt;
  logic [IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
  logic [63:0] mem_r, mem_nxt;
  logic pend_r, pend_nxt, tok_r, tok_nxt, poller_r, poller_nxt;
  logic tv_r, tv_nxt;
  logic [2:0] tk_r, tk_nxt;
  logic [5:0] td_r, td_nxt, ptr_r, ptr_nxt, left_r, left_nxt;
  logic [7:0] frm_r, frm_nxt;
  logic [31:0] cnt_r, cnt_nxt;

  // ----------------------------------------------------------------
  // derived values
  // ----------------------------------------------------------------
  logic [5:0] my, maxa, nxt_node, low_node;
  logic stall, wrap, wr, rd_go;
  logic [31:0] wmask, silence_lim;
  logic [7:0] own_ua, g2_ua;
  assign my = node_r[5:0];
  assign maxa = active_r[MAX_LSB +: 6];
  // waiting frame blocks the whole sequencer until the phy takes it
  assign stall = tv_r && !tx_ready;
  assign wr = wb_cyc_i && wb_stb_i && !ack_r && wb_we_i;
  assign rd_go = wb_cyc_i && wb_stb_i && !ack_r;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign own_ua = BUS_UA_BASE + {1'b0, unit_r}; // R12
  assign g2_ua = G2_UA_BASE + {4'h0, g2_r[3:0]} + {2'h0, g2_r[5:4], 4'h0}; // R13
  // higher addresses wait longer, so the lowest survivor wins takeover
  assign silence_lim = 32'(SILENCE_CYCLES) * {26'h0, my};

  // next present member above us, else the lowest member
  always_comb begin
    nxt_node = 6'h0;
    low_node = 6'h0;
    for (int i = 62; i >= 1; i--) begin
      if (mem_r[i] && 6'(i) <= maxa) begin // R17
        low_node = 6'(i);
        if (6'(i) > my) begin
          nxt_node = 6'(i); // R18
        end
      end
    end
  end
  assign wrap = (nxt_node == 6'h0); // R4

  // ----------------------------------------------------------------
  // next-state logic for bus, registers and token sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unit_nxt = 7'(sw_sync_r[15:12]) * 7'd10 + 7'(sw_sync_r[11:8]); // R10
    node_nxt = 7'(sw_sync_r[7:4]) * 7'd10 + 7'(sw_sync_r[3:0]); // R15
    unit_err_nxt = unit_nxt > UNIT_MAX || sw_sync_r[15:12] > DIGIT_MAX
      || sw_sync_r[11:8] > DIGIT_MAX; // R11
    node_err_nxt = node_nxt < NODE_MIN || node_nxt > NODE_MAX
      || sw_sync_r[7:4] > DIGIT_MAX || sw_sync_r[3:0] > DIGIT_MAX; // R16
    ctrl_en_nxt = ctrl_en_r;
    ack_nxt = rd_go;
    rdat_nxt = 32'h0;
    params_nxt = params_r;
    active_nxt = active_r;
    txw_nxt = txw_r;
    rxw_nxt = rxw_r;
    g2_nxt = g2_r;
    mask_nxt = mask_r;
    mem_nxt = mem_r;
    pend_nxt = pend_r;
    tok_nxt = tok_r;
    poller_nxt = poller_r;
    tv_nxt = stall;
    tk_nxt = tk_r;
    td_nxt = td_r;
    ptr_nxt = ptr_r;
    left_nxt = left_r;
    frm_nxt = frm_r;
    cnt_nxt = rx_valid ? 32'h0 : cnt_r + 32'h1;
    ev = '0;
    ev[IRQ_ERR] = (unit_err_nxt && !unit_err_r) || (node_err_nxt && !node_err_r);
    // register writes and reads
    if (wr) begin
      if (wb_adr_i == OFS_CTRL) begin
        ctrl_en_nxt = wb_sel_i[0] ? wb_dat_i[0] : ctrl_en_r;
      end else if (wb_adr_i == OFS_IRQ_MASK) begin
        mask_nxt = (mask_r & ~wmask[IRQ_W-1:0]) | (wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
      end else if (wb_adr_i == OFS_PARAMS) begin
        params_nxt = (params_r & ~wmask) | (wb_dat_i & wmask);
      end else if (wb_adr_i == OFS_TX && !pend_r) begin
        txw_nxt = wb_dat_i;
        pend_nxt = 1'b1;
      end else if (wb_adr_i == OFS_G2) begin
        g2_nxt = wb_dat_i[5:0];
      end
    end else if (rd_go) begin
      if (wb_adr_i == OFS_CTRL) begin
        rdat_nxt = {31'h0, ctrl_en_r};
      end else if (wb_adr_i == OFS_STATUS) begin
        rdat_nxt = {own_ua, 3'h0, pend_r, tok_r, poller_r, node_err_r, unit_err_r,
          1'b0, node_r, 1'b0, unit_r};
      end else if (wb_adr_i == OFS_IRQ_STAT) begin
        rdat_nxt = 32'(stat_r);
      end else if (wb_adr_i == OFS_IRQ_MASK) begin
        rdat_nxt = 32'(mask_r);
      end else if (wb_adr_i == OFS_PARAMS) begin
        rdat_nxt = params_r;
      end else if (wb_adr_i == OFS_ACTIVE) begin
        rdat_nxt = active_r;
      end else if (wb_adr_i == OFS_MEM_LO) begin
        rdat_nxt = mem_r[31:0];
      end else if (wb_adr_i == OFS_MEM_HI) begin
        rdat_nxt = mem_r[63:32];
      end else if (wb_adr_i == OFS_RX) begin
        rdat_nxt = rxw_r;
      end else if (wb_adr_i == OFS_G2) begin
        rdat_nxt = {24'h0, g2_ua};
      end
    end
    // frames that any enabled node answers, outside its own sequence
    if (rx_valid && state_r != S_OFF) begin
      if (rx_kind == K_MEMBERS && !poller_r) begin
        ev[IRQ_MEMBERS] = mem_r != rx_data;
        mem_nxt = rx_data; // R18
      end else if (rx_kind == K_PARAMS && !poller_r) begin
        active_nxt = rx_data[31:0]; // R9
      end else if (rx_kind == K_DATA && rx_dst == my
          && (rx_data[7:0] == own_ua || rx_data[7:0] == ALIAS_UA)) begin // R14
        rxw_nxt = rx_data[31:0];
        ev[IRQ_MSG] = 1'b1;
      end else if (rx_kind == K_PARAMS && poller_r && rx_src < my) begin
        poller_nxt = 1'b0; // lower node is back and polling again
        state_nxt = S_LISTEN;
      end
    end
    // token sequencer
    if (!stall) begin
      case (state_r)
        S_OFF: begin
          tok_nxt = 1'b0;
          poller_nxt = 1'b0;
          cnt_nxt = 32'h0;
          if (ctrl_en_r && !node_err_r && node_r[5:0] <= maxa) begin // R17
            mem_nxt = 64'h0;
            mem_nxt[my] = 1'b1;
            state_nxt = S_LISTEN;
          end
        end
        S_LISTEN: begin
          if (rx_valid && rx_kind == K_TOKEN && rx_dst == my) begin
            ev[IRQ_TOKEN] = 1'b1;
            frm_nxt = 8'h0;
            if (poller_r) begin
              left_nxt = active_r[POLL_LSB +: 6];
              state_nxt = S_POLL; // R6
            end else begin
              tok_nxt = 1'b1;
              state_nxt = S_HOLD;
            end
          end else if (rx_valid && rx_kind == K_POLL && rx_dst == my) begin
            tv_nxt = 1'b1;
            tk_nxt = K_ACK;
            td_nxt = rx_src;
          end else if (cnt_r >= silence_lim) begin
            poller_nxt = 1'b1; // R5
            ev[IRQ_POLLER] = 1'b1;
            for (int i = 0; i < 64; i++) begin
              if (6'(i) < my) begin
                mem_nxt[i] = 1'b0;
              end
            end
            left_nxt = active_r[POLL_LSB +: 6];
            state_nxt = S_POLL;
          end
        end
        S_HOLD: begin
          if (pend_r && frm_r < active_r[FRM_LSB +: 8]) begin
            tv_nxt = 1'b1; // R1
            tk_nxt = K_DATA;
            td_nxt = txw_r[13:8];
            pend_nxt = 1'b0;
            frm_nxt = frm_r + 8'h1;
          end else if (poller_r && wrap) begin
            tok_nxt = 1'b0;
            left_nxt = active_r[POLL_LSB +: 6];
            state_nxt = S_POLL; // R6
          end else begin
            tv_nxt = 1'b1; // R3
            tk_nxt = K_TOKEN;
            td_nxt = wrap ? low_node : nxt_node; // R2 R4
            tok_nxt = 1'b0;
            state_nxt = S_LISTEN;
          end
        end
        S_POLL: begin
          cnt_nxt = 32'h0;
          if (left_r == 6'h0) begin
            state_nxt = S_MEMB;
          end else if (ptr_r == my || ptr_r == 6'h0 || ptr_r > maxa) begin // R17
            ptr_nxt = (ptr_r >= maxa) ? 6'h1 : ptr_r + 6'h1; // R17
            left_nxt = left_r - 6'h1;
          end else begin
            tv_nxt = 1'b1; // R6
            tk_nxt = K_POLL;
            td_nxt = ptr_r;
            state_nxt = S_POLL_WAIT;
          end
        end
        S_POLL_WAIT: begin
          if ((rx_valid && rx_kind == K_ACK && rx_src == ptr_r) || cnt_r >= POLL_WAIT_CYC) begin
            // only the polled node's own answer marks it present
            mem_nxt[ptr_r] = rx_valid && rx_kind == K_ACK && rx_src == ptr_r;
            ev[IRQ_MEMBERS] = mem_r[ptr_r] != (rx_valid && rx_kind == K_ACK && rx_src == ptr_r);
            ptr_nxt = (ptr_r >= maxa) ? 6'h1 : ptr_r + 6'h1; // R17
            left_nxt = left_r - 6'h1;
            state_nxt = S_POLL;
          end
        end
        S_MEMB: begin
          tv_nxt = 1'b1; // R6
          tk_nxt = K_MEMBERS;
          td_nxt = BCAST_NODE;
          state_nxt = S_PARAM;
        end
        S_PARAM: begin
          tv_nxt = 1'b1; // R8
          tk_nxt = K_PARAMS;
          td_nxt = BCAST_NODE;
          active_nxt = params_r; // R9
          frm_nxt = 8'h0;
          tok_nxt = 1'b1; // R7
          state_nxt = S_HOLD;
        end
        default: state_nxt = S_OFF;
      endcase
    end
    if (!ctrl_en_r || node_err_r) begin
      state_nxt = S_OFF;
      tok_nxt = 1'b0;
      tv_nxt = stall;
    end
    // set wins over a write-one clear in the same cycle
    stat_nxt = stat_r & ~((wr && wb_adr_i == OFS_IRQ_STAT) ?
      (wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]) : '0);
    stat_nxt = stat_nxt | ev;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // frame payload follows the kind being launched
  logic [63:0] td_data_nxt, tx_data_r;
  always_comb begin
    td_data_nxt = tx_data_r;
    if (!stall && tv_nxt) begin
      td_data_nxt = (tk_nxt == K_MEMBERS) ? mem_r :
        (tk_nxt == K_PARAMS) ? {32'h0, params_r} :
        (tk_nxt == K_DATA) ? {32'h0, txw_r} : 64'h0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= S_OFF;
      unit_r <= 7'h0;
      node_r <= 7'h0;
      unit_err_r <= 1'b0;
      node_err_r <= 1'b0;
      ctrl_en_r <= 1'b0;
      ack_r <= 1'b0;
      irq_r <= 1'b0;
      rdat_r <= 32'h0;
      params_r <= PARAMS_RESET;
      active_r <= PARAMS_RESET;
      txw_r <= 32'h0;
      rxw_r <= 32'h0;
      g2_r <= 6'h0;
      stat_r <= '0;
      mask_r <= '0;
      mem_r <= 64'h0;
      pend_r <= 1'b0;
      tok_r <= 1'b0;
      poller_r <= 1'b0;
      tv_r <= 1'b0;
      tk_r <= K_TOKEN;
      td_r <= 6'h0;
      ptr_r <= 6'h1;
      left_r <= 6'h0;
      frm_r <= 8'h0;
      cnt_r <= 32'h0;
      tx_data_r <= 64'h0;
    end else begin
      state_r <= state_nxt;
      unit_r <= unit_nxt;
      node_r <= node_nxt;
      unit_err_r <= unit_err_nxt;
      node_err_r <= node_err_nxt;
      ctrl_en_r <= ctrl_en_nxt;
      ack_r <= ack_nxt;
      irq_r <= irq_nxt;
      rdat_r <= rdat_nxt;
      params_r <= params_nxt;
      active_r <= active_nxt;
      txw_r <= txw_nxt;
      rxw_r <= rxw_nxt;
      g2_r <= g2_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      mem_r <= mem_nxt;
      pend_r <= pend_nxt;
      tok_r <= tok_nxt;
      poller_r <= poller_nxt;
      tv_r <= tv_nxt;
      tk_r <= tk_nxt;
      td_r <= td_nxt;
      ptr_r <= ptr_nxt;
      left_r <= left_nxt;
      frm_r <= frm_nxt;
      cnt_r <= cnt_nxt;
      tx_data_r <= td_data_nxt;
    end
  end

  // outputs straight from flops
  assign wb_dat_o = rdat_r;
  assign wb_ack_o = ack_r;
  assign irq = irq_r;
  assign unit_number_error_lamp = unit_err_r;
  assign link_comm_error_lamp = node_err_r;
  assign tx_valid = tv_r;
  assign tx_kind = tk_r;
  assign tx_dst = td_r;
  assign tx_data = tx_data_r;
  assign token_held = tok_r;
  assign poller = poller_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  data_needs_token_a: assert property (tv_r && tk_r == K_DATA |-> tok_r) // R1
    else $error("data frame sent without token");
  pass_at_once_a: assert property (state_r == S_HOLD && !pend_r && !stall
      && !(poller_r && wrap) && ctrl_en_r && !node_err_r
      |=> tv_r && tk_r == K_TOKEN && !tok_r) // R3
    else $error("idle holder did not pass token");
  pass_order_a: assert property (state_r == S_HOLD && tv_nxt && tk_nxt == K_TOKEN && !stall
      |=> td_r == ($past(wrap) ? $past(low_node) : $past(nxt_node))) // R2
    else $error("token passed to wrong node");
  wrap_low_a: assert property (tv_r && tk_r == K_TOKEN && td_r <= my |-> td_r == low_node) // R4
    else $error("wrap did not return to lowest member");
  unit_lamp_a: assert property (unit_r > UNIT_MAX |-> unit_number_error_lamp) // R11
    else $error("unit number error lamp dark");
  // node_r still holds its reset zero in the first cycle after release
  node_lamp_a: assert property (!$past(reset) && (node_r < NODE_MIN || node_r > NODE_MAX)
      |-> link_comm_error_lamp ##1 state_r == S_OFF) // R16
    else $error("bad node address not flagged");
  poll_limit_a: assert property (tv_r && tk_r == K_POLL |-> td_r <= maxa && td_r != 6'h0) // R17
    else $error("poll beyond max address");
  bcast_seq_a: assert property (tv_r && tk_r == K_MEMBERS && tx_ready
      |=> tv_r && tk_r == K_PARAMS && tx_data[31:0] == params_r && tok_r) // R8
    else $error("parameters not sent after membership");
  alias_msg_a: assert property (rx_valid && rx_kind == K_DATA && rx_dst == my
      && rx_data[7:0] == ALIAS_UA && state_r != S_OFF |=> stat_r[IRQ_MSG]) // R14
    else $error("alias message not delivered");
  takeover_a: assert property (state_r == S_LISTEN && !stall && !rx_valid && ctrl_en_r
      && !node_err_r && cnt_r >= silence_lim |=> poller_r) // R5
    else $error("no takeover after silence");

  token_rx_c: cover property (state_r == S_LISTEN ##1 state_r == S_HOLD);
  poll_ack_c: cover property (state_r == S_POLL_WAIT && rx_valid && rx_kind == K_ACK);
  takeover_c: cover property (!poller_r ##1 poller_r);
  data_sent_c: cover property (tv_r && tk_r == K_DATA && tx_ready);
endmodule

// ---- token_node_pkg.sv ----
// shared constants for the token bus node controller
package token_node_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_PARAMS = 8'h10;
  localparam logic [7:0] OFS_ACTIVE = 8'h14;
  localparam logic [7:0] OFS_MEM_LO = 8'h18;
  localparam logic [7:0] OFS_MEM_HI = 8'h1c;
  localparam logic [7:0] OFS_TX = 8'h20;
  localparam logic [7:0] OFS_RX = 8'h24;
  localparam logic [7:0] OFS_G2 = 8'h28;
  // ----------------------------------------------------------------
  // parameter word layout and reset value
  // ----------------------------------------------------------------
  localparam int CYC_LSB = 0;
  localparam int POLL_LSB = 8;
  localparam int FRM_LSB = 16;
  localparam int MAX_LSB = 24;
  localparam logic [31:0] PARAMS_RESET = 32'h3e0a_0400;
  // ----------------------------------------------------------------
  // irq bits
  // ----------------------------------------------------------------
  localparam int IRQ_TOKEN = 0;
  localparam int IRQ_MEMBERS = 1;
  localparam int IRQ_MSG = 2;
  localparam int IRQ_ERR = 3;
  localparam int IRQ_POLLER = 4;
  localparam int IRQ_W = 5;
  // ----------------------------------------------------------------
  // frame kinds
  // ----------------------------------------------------------------
  localparam logic [2:0] K_TOKEN = 3'h0;
  localparam logic [2:0] K_DATA = 3'h1;
  localparam logic [2:0] K_POLL = 3'h2;
  localparam logic [2:0] K_ACK = 3'h3;
  localparam logic [2:0] K_MEMBERS = 3'h4;
  localparam logic [2:0] K_PARAMS = 3'h5;
  localparam logic [5:0] BCAST_NODE = 6'h3f;
  // ----------------------------------------------------------------
  // address ranges and unit addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] UNIT_MAX = 7'h0f;
  localparam logic [6:0] NODE_MIN = 7'h01;
  localparam logic [6:0] NODE_MAX = 7'h3e;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [7:0] HOST_UA = 8'h00;
  localparam logic [7:0] BOARD_UA = 8'h01;
  localparam logic [7:0] BUS_UA_BASE = 8'h10;
  localparam logic [7:0] ALIAS_UA = 8'hfe;
  localparam logic [7:0] G2_UA_BASE = 8'h90;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int POLL_WAIT_NS = 2000;
  localparam int POLL_WAIT_CYC = POLL_WAIT_NS / CLK_PERIOD_NS;
  localparam int SILENCE_NS = 100000;
  localparam int SILENCE_CYC = SILENCE_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_OFF, S_LISTEN, S_HOLD, S_POLL, S_POLL_WAIT, S_MEMB, S_PARAM}
    state_t;
endpackage

// ---- peer_trunk_model.sv ----
// behavioural model of the peer nodes sharing the trunk line
`timescale 1ns/1ps
module peer_trunk_model
  import token_node_pkg::*;
#(
  parameter logic [5:0] PEER = 6'd5
) (
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [2:0] tx_kind,
  input wire logic [5:0] tx_dst,
  input wire logic [63:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [2:0] rx_kind,
  output logic [5:0] rx_src,
  output logic [5:0] rx_dst,
  output logic [63:0] rx_data
);
  logic slow = 1'b0;
  logic acc_new = 1'b0;
  logic [2:0] acc_kind = 3'h0;
  logic [5:0] acc_dst = 6'h00;
  logic [63:0] acc_data = 64'h0;
  logic [3:0] tick = 4'h0;
  int ack_wait = 0;
  int req_cnt = 0;
  int done_cnt = 0;
  logic [2:0] q_kind;
  logic [5:0] q_src;
  logic [5:0] q_dst;
  logic [63:0] q_data;
  // slow mode is ready one cycle in four, as a busy trunk would be
  assign tx_ready = !slow || tick[1:0] == 2'h0;
  initial begin
    rx_valid = 1'b0;
    rx_kind = 3'h7;
    rx_src = 6'h2a;
    rx_dst = 6'h15;
    rx_data = 64'h0;
  end
  // frame capture, poll answers, one frame per pulse on receive
  always @(posedge clk) begin
    tick <= tick + 4'h1;
    acc_new <= tx_valid && tx_ready;
    if (tx_valid && tx_ready) begin
      acc_kind <= tx_kind;
      acc_dst <= tx_dst;
      acc_data <= tx_data;
    end
    if (tx_valid && tx_ready && tx_kind == K_POLL && tx_dst == PEER) begin
      ack_wait <= 3;
    end else if (ack_wait > 0) begin
      ack_wait <= ack_wait - 1;
    end
    if (ack_wait == 1) begin
      rx_valid <= 1'b1;
      {rx_kind, rx_src, rx_dst, rx_data} <= {K_ACK, PEER, tx_dst, 64'h0};
    end else if (req_cnt != done_cnt) begin
      rx_valid <= 1'b1;
      {rx_kind, rx_src, rx_dst, rx_data} <= {q_kind, q_src, q_dst, q_data};
      done_cnt <= done_cnt + 1;
    end else begin
      // released lines flip to the inverse each idle cycle, so the stale frame shows again every other cycle
      rx_valid <= 1'b0;
      {rx_kind, rx_src, rx_dst, rx_data} <= ~{rx_kind, rx_src, rx_dst, rx_data};
    end
  end
  task automatic send(input logic [2:0] k, input logic [5:0] s, input logic [5:0] d,
    input logic [63:0] x);
    // request posted just after an edge, so the capture process never races it
    @(posedge clk);
    {q_kind, q_src, q_dst, q_data} <= {k, s, d, x};
    req_cnt <= req_cnt + 1;
    do @(posedge clk); while (done_cnt != req_cnt);
  endtask
endmodule

// ---- token_bus_node_control_tb_top.sv ----
// self-checking testbench for the token bus node controller
`timescale 1ns/1ps
module token_bus_node_control_tb_top;
  import token_node_pkg::*;
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, ack, irq, ul, nl, tv, tr, rv, th, pl;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rdat, q, w;
  logic [3:0] ut = 0, uo = 0, nt = 0, no = 0, s;
  logic [2:0] tk, rk;
  logic [5:0] td, rs, rd;
  logic [63:0] tdat, rdd;
  int seed = 32'h3e6d, n_mismatch = 0, total_checks = 0, cycles = 0;
  logic [7:0] seed_units [3] = '{ALIAS_UA, 8'h55, 8'h1c};
  token_node_ctrl #(.SILENCE_CYCLES(20)) dut_u (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .unit_tens_switch(ut),
    .unit_ones_switch(uo), .node_tens_switch(nt), .node_ones_switch(no),
    .unit_number_error_lamp(ul), .link_comm_error_lamp(nl), .tx_valid(tv), .tx_ready(tr),
    .tx_kind(tk), .tx_dst(td), .tx_data(tdat), .rx_valid(rv), .rx_kind(rk), .rx_src(rs),
    .rx_dst(rd), .rx_data(rdd), .token_held(th), .poller(pl));
  peer_trunk_model peer_u (.clk(clk), .tx_valid(tv), .tx_kind(tk), .tx_dst(td),
    .tx_data(tdat), .tx_ready(tr), .rx_valid(rv), .rx_kind(rk), .rx_src(rs), .rx_dst(rd),
    .rx_data(rdd));
  initial forever #5 clk = ~clk;
  // hang guard sized well above the longest scenario
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // classic single wishbone cycle, held until ack is sampled
  // only the bench timeout ends a wait for ack
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'b11, wr, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  // returns at the edge after capture, before the next frame overwrites it
  task automatic wait_kind(input logic [2:0] k);
    do @(posedge clk); while (!(peer_u.acc_new === 1'b1 && peer_u.acc_kind == k));
  endtask
  function automatic logic u_err(input logic [3:0] t, input logic [3:0] o);
    return t > 9 || o > 9 || t * 10 + o > 15;
  endfunction
  function automatic logic n_err(input logic [3:0] t, input logic [3:0] o);
    return t > 9 || o > 9 || t * 10 + o < 1 || t * 10 + o > 62;
  endfunction
  initial begin
    repeat (12) @(posedge clk);
    reset <= 0;
    wb(0, OFS_PARAMS, 0);
    chk(q, 32'h3e0a_0400);
    wb(0, 8'h3c, 0);
    chk(q, 0);
    $display("test reset done");
    // unit number corners 15 and 16 first, then random digits
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      {ut, uo, nt, no} <= (i == 0) ? 16'h1506 : (i == 1) ? 16'h1606 : 16'($random(seed));
      repeat (5) @(posedge clk);
      chk(ul, u_err(ut, uo));
      chk(nl, n_err(nt, no));
      wb(0, OFS_STATUS, 0);
      if (!n_err(nt, no)) chk(q[14:8], nt * 10 + no);
      if (!u_err(ut, uo)) chk(q[31:24], BUS_UA_BASE + ut * 10 + uo);
    end
    {ut, uo, nt, no} <= 16'h1203;
    for (int i = 0; i < 6; i++) begin
      s = 4'($random(seed));
      w = {26'h0, 2'($random(seed)), s};
      wb(1, OFS_G2, w);
      wb(0, OFS_G2, 0);
      chk(q[7:0], G2_UA_BASE + s + 16 * w[5:4]);
    end
    $display("test switches done");
    wb(1, OFS_CTRL, 1);
    peer_u.send(K_MEMBERS, 6'd1, BCAST_NODE, 64'h228);
    peer_u.send(K_TOKEN, 6'd9, 6'd3, 0);
    wait_kind(K_TOKEN);
    chk(peer_u.acc_dst, 6'd5);
    chk(irq, 0);
    wb(1, OFS_IRQ_MASK, 1 << IRQ_TOKEN);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    wb(1, OFS_IRQ_STAT, 32'h1f);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    w = {16'hbeef, 2'h0, 6'd5, ALIAS_UA};
    wb(1, OFS_TX, w);
    peer_u.send(K_TOKEN, 6'd9, 6'd3, 0);
    wait_kind(K_DATA);
    chk(peer_u.acc_data, {32'h0, w});
    wait_kind(K_TOKEN);
    chk(peer_u.acc_dst, 6'd5);
    peer_u.send(K_MEMBERS, 6'd1, BCAST_NODE, 64'ha);
    peer_u.send(K_TOKEN, 6'd1, 6'd3, 0);
    wait_kind(K_TOKEN);
    chk(peer_u.acc_dst, 6'd1);
    $display("test token done");
    w = 0;
    foreach (seed_units[i]) begin
      peer_u.send(K_DATA, 6'd5, 6'd3, {32'h0, 16'(i + 1), 2'h0, 6'd3, seed_units[i]});
      if (seed_units[i] != 8'h55) w = {16'(i + 1), 2'h0, 6'd3, seed_units[i]};
      wb(0, OFS_RX, 0);
      chk(q, w);
    end
    $display("test message done");
    w = {8'h3e, 8'($random(seed)), 8'h04, 8'($random(seed))};
    wb(1, OFS_PARAMS, w);
    peer_u.slow <= 1;
    wait_kind(K_POLL);
    chk(pl, 1);
    wait_kind(K_MEMBERS);
    chk(peer_u.acc_dst, BCAST_NODE);
    wait_kind(K_PARAMS);
    chk(peer_u.acc_data, {32'h0, w});
    wait_kind(K_TOKEN);
    chk(peer_u.acc_dst, 6'd5);
    $display("test takeover done");
    end_of_test();
  end
endmodule
